/* verilog/timer8_pkg.sv */
// constants shared by the 8-bit timer compare block
package timer8_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_FORCE = 5'h04;
	localparam logic [4:0] ADDR_COUNTER = 5'h08;
	localparam logic [4:0] ADDR_COMPARE_A = 5'h0c;
	localparam logic [4:0] ADDR_COMPARE_B = 5'h10;
	localparam logic [4:0] ADDR_FLAGS = 5'h14;
	localparam logic [4:0] ADDR_PORT = 5'h18;
	localparam logic [4:0] ADDR_STATUS = 5'h1c;
	localparam int ADDR_W = 5;

	// control register fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_COM_A_LSB = 4;
	localparam int CTL_COM_B_LSB = 6;
	// force register bits
	localparam int FORCE_A_BIT = 0;
	localparam int FORCE_B_BIT = 1;
	// flag register bits
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_A_BIT = 1;
	localparam int FLAG_CMP_B_BIT = 2;
	// port register bits
	localparam int PORT_OUT_A_BIT = 0;
	localparam int PORT_OUT_B_BIT = 1;
	localparam int PORT_DIR_A_BIT = 4;
	localparam int PORT_DIR_B_BIT = 5;
	// status register bits
	localparam int STAT_OCS_A_BIT = 0;
	localparam int STAT_OCS_B_BIT = 1;

	// waveform modes
	localparam logic [2:0] WAVE_NORMAL = 3'h0;
	localparam logic [2:0] WAVE_CLEAR_ON_MATCH = 3'h2;
	localparam logic [2:0] WAVE_CTC_TOP_FIXED = 3'h6;

	// compare output modes in non-PWM modes
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	// counter extremes and reset values
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

/* verilog/timer8_compare.sv */
// 8-bit timer/counter with two compare channels, normal and clear-on-match modes
//
// Functional notes
// R1 - a counter write blocks every compare match on the next timer tick, even stopped
// R2 - a counter write wins over clear or count in the same cycle
// R3 - software avoids writing counter equal to compare value or zero when down-counting
// R4 - software sets compare output state before turning the pin to output
// R5 - compare output state is kept unchanged across waveform mode changes
// R6 - compare output mode is unbuffered, used from the first match after write
// R7 - nonzero compare output mode drives pin from compare output state
// R8 - pin direction stays with the direction bit during override
// R9 - pin override choice depends only on compare output mode
// R10 - compare output state can be initialised before pin output is enabled
// R11 - compare output mode zero leaves compare output state untouched on matches
// R12 - force strobe applies the output action at once in non-PWM modes
// R13 - forced compare sets no flag and never touches the counter
// R14 - counting depends only on waveform mode, never on compare output mode
// R15 - in non-PWM modes the output mode selects set, clear or toggle
// R16 - output mode 2 clears, 3 sets compare output state on a match
// R17 - normal mode always increments, wraps 0xff to 0x00
// R18 - overflow flag sets in the tick the counter goes from max to zero
// R19 - hardware only sets overflow flag; service or software clears it
// R20 - match sets compare flag at next tick; write one or service clears
// R21 - normal mode accepts counter writes at any time
// R22 - clear-on-match mode clears counter when it matches compare value a
// R23 - clear-on-match raises compare flag a each period
// R24 - compare value a unbuffered; below counter means wrap through 0xff first
// R25 - toggle on channel a in clear-on-match gives square wave
// R26 - toggle rate is tick rate over twice one plus compare value a
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps

module timer8_compare
	import timer8_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// timer tick from clock select, one cycle per count
	input wire logic timer_tick_i,
	// interrupt service acknowledges, one-cycle pulses
	input wire logic overflow_serviced_i,
	input wire logic compare_a_serviced_i,
	input wire logic compare_b_serviced_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// event flags as levels
	output logic overflow_flag_o,
	output logic compare_flag_a_o,
	output logic compare_flag_b_o,
	// compare output pins
	output logic pin_a_o,
	output logic pin_a_oe_o,
	output logic pin_b_o,
	output logic pin_b_oe_o
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [2:0] waveform_mode;
		logic [1:0] compare_output_mode_a;
		logic [1:0] compare_output_mode_b;
		logic [7:0] counter_value;
		logic [7:0] compare_value_a;
		logic [7:0] compare_value_b;
		logic block_match;
		logic overflow_flag;
		logic compare_flag_a;
		logic compare_flag_b;
		logic compare_output_state_a;
		logic compare_output_state_b;
		logic port_out_a;
		logic port_out_b;
		logic pin_dir_a;
		logic pin_dir_b;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// only modes without pwm let the output action and force strobe act
	function automatic logic non_pwm(input logic [2:0] mode);
		non_pwm = (mode == WAVE_NORMAL) || (mode == WAVE_CLEAR_ON_MATCH);
	endfunction

	// new compare output state for a match or a forced match
	function automatic logic compare_action(input logic [1:0] com, input logic cur);
		case (com)
			COM_TOGGLE: compare_action = ~cur; // [R15] [R25]
			COM_CLEAR: compare_action = 1'b0; // [R16]
			COM_SET: compare_action = 1'b1; // [R16]
			default: compare_action = cur; // [R11]
		endcase
	endfunction

	// byte lane merge for one 8-bit register in the low byte
	function automatic logic [7:0] lane0(input logic [7:0] cur, input logic [3:0] sel,
		input logic [31:0] data);
		lane0 = sel[0] ? data[7:0] : cur;
	endfunction

	logic access;
	logic first_cycle;
	logic wr;
	logic match_a;
	logic match_b;
	logic ctc_clear;
	logic [31:0] read_mux;

	always_comb begin
		access = cyc_i && stb_i;
		first_cycle = access && !state_reg.ack;
		// a write lands at the edge where the master samples ack
		wr = access && state_reg.ack && we_i;

		// raw compare, suppressed for one tick after a counter write
		match_a = (state_reg.counter_value == state_reg.compare_value_a)
			&& !state_reg.block_match; // [R1]
		match_b = (state_reg.counter_value == state_reg.compare_value_b)
			&& !state_reg.block_match; // [R1]
		ctc_clear = (state_reg.waveform_mode == WAVE_CLEAR_ON_MATCH) && match_a; // [R14]

		read_mux = READ_ZERO;
		if (adr_i == ADDR_CONTROL) begin
			read_mux[CTL_MODE_LSB +: 3] = state_reg.waveform_mode;
			read_mux[CTL_COM_A_LSB +: 2] = state_reg.compare_output_mode_a;
			read_mux[CTL_COM_B_LSB +: 2] = state_reg.compare_output_mode_b;
		end else if (adr_i == ADDR_COUNTER) begin
			read_mux[7:0] = state_reg.counter_value;
		end else if (adr_i == ADDR_COMPARE_A) begin
			read_mux[7:0] = state_reg.compare_value_a;
		end else if (adr_i == ADDR_COMPARE_B) begin
			read_mux[7:0] = state_reg.compare_value_b;
		end else if (adr_i == ADDR_FLAGS) begin
			read_mux[FLAG_OVF_BIT] = state_reg.overflow_flag;
			read_mux[FLAG_CMP_A_BIT] = state_reg.compare_flag_a;
			read_mux[FLAG_CMP_B_BIT] = state_reg.compare_flag_b;
		end else if (adr_i == ADDR_PORT) begin
			read_mux[PORT_OUT_A_BIT] = state_reg.port_out_a;
			read_mux[PORT_OUT_B_BIT] = state_reg.port_out_b;
			read_mux[PORT_DIR_A_BIT] = state_reg.pin_dir_a;
			read_mux[PORT_DIR_B_BIT] = state_reg.pin_dir_b;
		end else if (adr_i == ADDR_STATUS) begin
			read_mux[STAT_OCS_A_BIT] = state_reg.compare_output_state_a;
			read_mux[STAT_OCS_B_BIT] = state_reg.compare_output_state_b;
		end
		// force register and unmapped addresses read zero
	end

	always_comb begin
		state_next = state_reg;

		// bus handshake: ack for exactly one cycle per request
		state_next.ack = first_cycle;
		if (first_cycle) begin
			state_next.rdata = read_mux;
		end

		// timer tick: count, clear, flags and output actions
		if (timer_tick_i) begin
			state_next.block_match = 1'b0;
			if (ctc_clear) begin
				state_next.counter_value = COUNT_BOTTOM; // [R22] [R24]
			end else begin
				// normal and every other mode count up and wrap
				state_next.counter_value = state_reg.counter_value + 8'h01; // [R17] [R24]
			end
			if (state_reg.counter_value == COUNT_MAX) begin
				state_next.overflow_flag = 1'b1; // [R18] [R19]
			end
			if (match_a) begin
				state_next.compare_flag_a = 1'b1; // [R20] [R23]
			end
			if (match_b) begin
				state_next.compare_flag_b = 1'b1; // [R20]
			end
			// the mode currently held is used, so a fresh setting acts at once
			if (match_a && non_pwm(state_reg.waveform_mode)) begin
				state_next.compare_output_state_a = compare_action(
					state_reg.compare_output_mode_a,
					state_reg.compare_output_state_a); // [R6] [R15] [R25] [R26]
			end
			if (match_b && non_pwm(state_reg.waveform_mode)) begin
				state_next.compare_output_state_b = compare_action(
					state_reg.compare_output_mode_b,
					state_reg.compare_output_state_b); // [R6] [R15]
			end
		end

		// software clears flags by writing one; a same-cycle set still wins
		if (wr && (adr_i == ADDR_FLAGS) && sel_i[0]) begin
			if (dat_i[FLAG_OVF_BIT] && !(timer_tick_i
				&& state_reg.counter_value == COUNT_MAX)) begin
				state_next.overflow_flag = 1'b0; // [R19]
			end
			if (dat_i[FLAG_CMP_A_BIT] && !(timer_tick_i && match_a)) begin
				state_next.compare_flag_a = 1'b0; // [R20]
			end
			if (dat_i[FLAG_CMP_B_BIT] && !(timer_tick_i && match_b)) begin
				state_next.compare_flag_b = 1'b0; // [R20]
			end
		end
		// interrupt service clears, again losing to a same-tick set
		if (overflow_serviced_i && !(timer_tick_i
			&& state_reg.counter_value == COUNT_MAX)) begin
			state_next.overflow_flag = 1'b0; // [R19]
		end
		if (compare_a_serviced_i && !(timer_tick_i && match_a)) begin
			state_next.compare_flag_a = 1'b0; // [R20]
		end
		if (compare_b_serviced_i && !(timer_tick_i && match_b)) begin
			state_next.compare_flag_b = 1'b0; // [R20]
		end

		// register writes
		if (wr && (adr_i == ADDR_CONTROL) && sel_i[0]) begin
			// the compare output states are deliberately left alone here
			state_next.waveform_mode = dat_i[CTL_MODE_LSB +: 3]; // [R5]
			state_next.compare_output_mode_a = dat_i[CTL_COM_A_LSB +: 2]; // [R6]
			state_next.compare_output_mode_b = dat_i[CTL_COM_B_LSB +: 2]; // [R6]
		end else if (wr && (adr_i == ADDR_FORCE) && sel_i[0]) begin
			// forced match: no flag, no counter change, output state only
			if (dat_i[FORCE_A_BIT] && non_pwm(state_reg.waveform_mode)) begin
				state_next.compare_output_state_a = compare_action(
					state_reg.compare_output_mode_a,
					state_reg.compare_output_state_a); // [R10] [R12] [R13]
			end
			if (dat_i[FORCE_B_BIT] && non_pwm(state_reg.waveform_mode)) begin
				state_next.compare_output_state_b = compare_action(
					state_reg.compare_output_mode_b,
					state_reg.compare_output_state_b); // [R10] [R12] [R13]
			end
		end else if (wr && (adr_i == ADDR_COUNTER) && sel_i[0]) begin
			// overrides the tick's count or clear above, stopped or running
			state_next.counter_value = dat_i[7:0]; // [R2] [R21]
			state_next.block_match = 1'b1; // [R1]
		end else if (wr && (adr_i == ADDR_COMPARE_A)) begin
			// unbuffered: a value below the counter is only met after the wrap
			state_next.compare_value_a = lane0(state_reg.compare_value_a, sel_i,
				dat_i); // [R24]
		end else if (wr && (adr_i == ADDR_COMPARE_B)) begin
			state_next.compare_value_b = lane0(state_reg.compare_value_b, sel_i, dat_i);
		end else if (wr && (adr_i == ADDR_PORT) && sel_i[0]) begin
			state_next.port_out_a = dat_i[PORT_OUT_A_BIT];
			state_next.port_out_b = dat_i[PORT_OUT_B_BIT];
			state_next.pin_dir_a = dat_i[PORT_DIR_A_BIT];
			state_next.pin_dir_b = dat_i[PORT_DIR_B_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.counter_value <= COUNT_RESET;
			state_reg.compare_value_a <= COMPARE_RESET;
			state_reg.compare_value_b <= COMPARE_RESET;
			state_reg.waveform_mode <= WAVE_NORMAL;
			state_reg.compare_output_mode_a <= COM_OFF;
			state_reg.compare_output_mode_b <= COM_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// pin drivers; override follows the output mode alone, not the waveform mode
	always_comb begin
		pin_a_o = (state_reg.compare_output_mode_a != COM_OFF)
			? state_reg.compare_output_state_a : state_reg.port_out_a; // [R7] [R9]
		pin_b_o = (state_reg.compare_output_mode_b != COM_OFF)
			? state_reg.compare_output_state_b : state_reg.port_out_b; // [R7] [R9]
		// the direction bit alone enables the driver, also during override
		pin_a_oe_o = state_reg.pin_dir_a; // [R8]
		pin_b_oe_o = state_reg.pin_dir_b; // [R8]
	end

	assign dat_o = state_reg.rdata;
	assign ack_o = state_reg.ack;
	assign overflow_flag_o = state_reg.overflow_flag;
	assign compare_flag_a_o = state_reg.compare_flag_a;
	assign compare_flag_b_o = state_reg.compare_flag_b;

endmodule

/* testbench/timer8_compare_monitor.sv */
// assertion checker for the 8-bit timer compare block
`timescale 1ns/10ps
module timer8_compare_monitor
	import timer8_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic timer_tick_i,
	input wire logic overflow_serviced_i,
	input wire logic compare_a_serviced_i,
	input wire logic compare_b_serviced_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic overflow_flag_o,
	input wire logic compare_flag_a_o,
	input wire logic compare_flag_b_o,
	input wire logic pin_a_o,
	input wire logic pin_a_oe_o,
	input wire logic pin_b_o,
	input wire logic pin_b_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr;
	logic [1:0] com_a_sh;
	logic out_a_sh;
	// shadow of the bus writes, so port tests need no internal state
	assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			com_a_sh <= COM_OFF;
			out_a_sh <= 1'b0;
		end else if (wr && adr_i == ADDR_CONTROL) begin
			com_a_sh <= dat_i[CTL_COM_A_LSB +: 2];
		end else if (wr && adr_i == ADDR_PORT) begin
			out_a_sh <= dat_i[PORT_OUT_A_BIT];
		end
	end
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_ack; ack_o ##1 !ack_o; endsequence
	property p_ack_once; s_req |=> s_ack; endproperty
	property p_ack_cause; !(cyc_i && stb_i) |=> !ack_o; endproperty
	property p_ovf_keep; overflow_flag_o && !overflow_serviced_i
		&& !(wr && adr_i == ADDR_FLAGS && dat_i[FLAG_OVF_BIT]) |=> overflow_flag_o; endproperty
	property p_cmp_keep; compare_flag_a_o && !compare_a_serviced_i
		&& !(wr && adr_i == ADDR_FLAGS && dat_i[FLAG_CMP_A_BIT]) |=> compare_flag_a_o; endproperty
	property p_ovf_tick; !overflow_flag_o && !timer_tick_i |=> !overflow_flag_o; endproperty
	property p_cmp_tick; !compare_flag_a_o && !timer_tick_i |=> !compare_flag_a_o; endproperty
	property p_dir_hold; !(wr && adr_i == ADDR_PORT) |=> $stable(pin_a_oe_o) && $stable(pin_b_oe_o);
	endproperty
	property p_port_pass; com_a_sh == COM_OFF |-> pin_a_o == out_a_sh; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag dropped");
	a_cmp_keep: assert property (p_cmp_keep) else $error("compare flag dropped");
	a_ovf_tick: assert property (p_ovf_tick) else $error("overflow set off tick");
	a_cmp_tick: assert property (p_cmp_tick) else $error("compare flag set off tick");
	a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
	a_port_pass: assert property (p_port_pass) else $error("pin not port value");
endmodule
bind timer8_compare timer8_compare_monitor timer8_compare_monitor_inst (.*);

/* testbench/pin_pad_model.sv */
// pad model: resolves the timer output pins onto pulled-up pads
`timescale 1ns/10ps
module pin_pad_model (
	input wire logic pin_a_i,
	input wire logic pin_a_oe_i,
	input wire logic pin_b_i,
	input wire logic pin_b_oe_i,
	output logic pad_a_o,
	output logic pad_b_o
);
	// an undriven pad sits at the pull-up level, never the last driven value
	assign pad_a_o = pin_a_oe_i ? pin_a_i : 1'b1;
	assign pad_b_o = pin_b_oe_i ? pin_b_i : 1'b1;
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the 8-bit timer compare block
`timescale 1ns/10ps
module tb_top
	import timer8_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic timer_tick_i = 1'b0;
	logic overflow_serviced_i = 1'b0;
	logic compare_a_serviced_i = 1'b0;
	logic compare_b_serviced_i = 1'b0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd;
	logic [31:0] seed = 32'h3c;
	logic ack_o, overflow_flag_o, compare_flag_a_o, compare_flag_b_o, st;
	logic pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o, pad_a, pad_b;
	logic [7:0] top;
	int bad_count = 0;
	int check_count = 0;
	timer8_compare timer8_compare_inst (.*);
	pin_pad_model pin_pad_model_inst (.pin_a_i(pin_a_o), .pin_a_oe_i(pin_a_oe_o),
		.pin_b_i(pin_b_o), .pin_b_oe_i(pin_b_oe_o), .pad_a_o(pad_a), .pad_b_o(pad_b));
	always #5 clk_i = ~clk_i;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic act(input logic [1:0] c, input logic s);
		case (c)
			COM_TOGGLE: return ~s;
			COM_CLEAR: return 1'b0;
			COM_SET: return 1'b1;
			default: return s;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		// look at ack between edges, then act on the edge that samples it high
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		@(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, e, rd);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			timer_tick_i <= 1'b1;
			@(posedge clk_i);
			timer_tick_i <= 1'b0;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(5'h03, 32'h0, "unmapped");
		wb(1'b1, ADDR_COUNTER, 8'hfd);
		tick(3);
		rdchk(ADDR_COUNTER, 32'h0, "wrap");
		rdchk(ADDR_FLAGS, 32'h1, "ovf_set");
		@(posedge clk_i);
		overflow_serviced_i <= 1'b1;
		@(posedge clk_i);
		overflow_serviced_i <= 1'b0;
		rdchk(ADDR_FLAGS, 32'h0, "ovf_clr");
		wb(1'b1, ADDR_COMPARE_A, 8'h05);
		wb(1'b1, ADDR_COMPARE_B, 8'h06);
		wb(1'b1, ADDR_COUNTER, 8'h05);
		tick(1);
		rdchk(ADDR_FLAGS, 32'h0, "blocked");
		tick(1);
		rdchk(ADDR_FLAGS, 32'h4, "match_b");
		wb(1'b1, ADDR_FLAGS, 8'h04);
		rdchk(ADDR_FLAGS, 32'h0, "w1c");
		st = 1'b0;
		for (int c = 3; c >= 0; c--) begin
			wb(1'b1, ADDR_CONTROL, {2'h0, c[1:0], 4'h0});
			wb(1'b1, ADDR_FORCE, 8'h01);
			st = act(c[1:0], st);
			rdchk(ADDR_STATUS, {31'h0, st}, "force");
			rdchk(ADDR_FLAGS, 32'h0, "force_flag");
		end
		// output state is settled above before the pin is turned to output
		wb(1'b1, ADDR_PORT, 8'h10);
		@(negedge clk_i);
		chk("pad_port", 32'h0, {31'h0, pad_a});
		wb(1'b1, ADDR_CONTROL, 8'h12);
		@(negedge clk_i);
		chk("pad_ovr", {31'h0, st}, {31'h0, pad_a});
		top = 8'h03;
		wb(1'b1, ADDR_COUNTER, 8'h00);
		repeat (4) begin
			wb(1'b1, ADDR_COMPARE_A, top);
			tick(top + 1);
			st = act(COM_TOGGLE, st);
			rdchk(ADDR_COUNTER, 32'h0, "ctc_clear");
			rdchk(ADDR_STATUS, {31'h0, st}, "ctc_toggle");
			chk("ctc_flag", 32'h1, {31'h0, compare_flag_a_o});
			@(posedge clk_i);
			compare_a_serviced_i <= 1'b1;
			@(posedge clk_i);
			compare_a_serviced_i <= 1'b0;
			rd = xs();
			top = {5'h00, rd[2:0]};
		end
		wb(1'b1, ADDR_COMPARE_A, 8'h80);
		tick(2);
		wb(1'b1, ADDR_COMPARE_A, 8'h01);
		tick(255);
		rdchk(ADDR_FLAGS, 32'h5, "late_top");
		tick(1);
		@(negedge clk_i);
		chk("late_match", 32'h1, {31'h0, compare_flag_a_o});
		wb(1'b1, ADDR_PORT, 8'h00);
		@(negedge clk_i);
		chk("pad_off", 32'h1, {31'h0, pad_a});
		print_verdict();
	end
endmodule
